/* rtl/iep_pkg.sv */
// Constants for the interrupt enable bank of comparator, pulse and pin sources.
// Assumes an APB slave with 32-bit data and one clock domain.
package iep_pkg;
    localparam int REG_W = 16;
    localparam logic [11:0] OFF_ENABLE = 12'h000;
    localparam logic [11:0] OFF_STATUS = 12'h004;
    localparam logic [11:0] OFF_CLEAR = 12'h008;
    localparam logic [11:0] OFF_IRQ_EN = 12'h00C;
    localparam logic [11:0] OFF_PENDING = 12'h010;
    localparam int BIT_CMP3 = 15;
    localparam int BIT_CMP2 = 14;
    localparam int BIT_CMP1 = 13;
    localparam int BIT_CHG = 11;
    localparam int BIT_PG4 = 6;
    localparam int BIT_PG3 = 5;
    localparam int BIT_PG2 = 4;
    localparam int BIT_PG1 = 3;
    localparam int BIT_PSE = 2;
    localparam int BIT_EXT2 = 1;
    localparam int BIT_EXT1 = 0;
    localparam logic [15:0] IMPL_MASK = 16'hE87F;
    localparam logic [15:0] ENABLE_RST = 16'h0000;
    localparam logic [1:0] EV_NONE = 2'h0;
    localparam logic [1:0] EV_GRANT_RISE = 2'h1;
    localparam logic [1:0] EV_BLOCKED = 2'h2;
endpackage

/* rtl/iep_gate.sv */
// Per-source request gate: one enable bit joins one pending flag.
// Assumes flags are synchronous to ref_clk.
module iep_gate
    import iep_pkg::*;
#(
    parameter int WIDTH = REG_W
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] flags,
    input wire logic [WIDTH-1:0] enables,
    output logic [WIDTH-1:0] requests
);
    if (WIDTH < 1) begin : gen_bad_width
        $error("iep_gate width must be positive");
    end

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : gen_gate
            always_ff @(posedge ref_clk or negedge rst_b) begin
                if (!rst_b) begin
                    requests[g] <= 1'b0;
                end else begin
                    requests[g] <= flags[g] & enables[g];
                end
            end
        end
    endgenerate

    a_gate_block: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        !enables[0] |=> !requests[0])
        else $error("request passed while disabled");
    a_gate_pass: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (enables[0] && flags[0]) |=> requests[0])
        else $error("enabled request not passed");
endmodule

/* rtl/iep_bank.sv */
// Top of the interrupt enable bank with APB slave and event interrupt.
// Assumes synchronous source flags and an APB master on ref_clk.
module iep_bank
    import iep_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [REG_W-1:0] srcFlags,
    output logic [REG_W-1:0] ctrlRequest,
    output logic irq
);
    logic [REG_W-1:0] enable_r;
    logic [REG_W-1:0] status_r;
    logic [REG_W-1:0] irqEn_r;
    logic [REG_W-1:0] grant;
    logic [REG_W-1:0] grantPrev_r;
    logic [REG_W-1:0] blockedEv;
    logic [REG_W-1:0] blockedPrev_r;
    logic [REG_W-1:0] evSet;
    logic [REG_W-1:0] clrMask;
    logic setup;
    logic wrAcc;
    logic [1:0] lastEv_r;
    logic comparator3IrqEn;
    logic comparator2IrqEn;
    logic comparator1IrqEn;
    logic changeNotifyIrqEn;
    logic pulseGen4IrqEn;
    logic pulseGen3IrqEn;
    logic pulseGen2IrqEn;
    logic pulseGen1IrqEn;
    logic pulseSpecialEventIrqEn;
    logic extPin2IrqEn;
    logic extPin1IrqEn;

    function automatic logic known(input logic [11:0] a);
        return a == OFF_ENABLE || a == OFF_STATUS || a == OFF_CLEAR ||
            a == OFF_IRQ_EN || a == OFF_PENDING;
    endfunction

    assign setup = psel && !penable;
    assign wrAcc = psel && penable && pready && pwrite && !pslverr;
    assign grant = srcFlags & enable_r;
    assign blockedEv = srcFlags & ~enable_r & IMPL_MASK;
    assign evSet = (grant & ~grantPrev_r) | (blockedEv & ~blockedPrev_r);
    assign clrMask = (wrAcc && paddr == OFF_CLEAR) ?
        pwdata[REG_W-1:0] : '0;

    // Named enable fields
    assign comparator3IrqEn = enable_r[BIT_CMP3];
    assign comparator2IrqEn = enable_r[BIT_CMP2];
    assign comparator1IrqEn = enable_r[BIT_CMP1];
    assign changeNotifyIrqEn = enable_r[BIT_CHG];
    assign pulseGen4IrqEn = enable_r[BIT_PG4];
    assign pulseGen3IrqEn = enable_r[BIT_PG3];
    assign pulseGen2IrqEn = enable_r[BIT_PG2];
    assign pulseGen1IrqEn = enable_r[BIT_PG1];
    assign pulseSpecialEventIrqEn = enable_r[BIT_PSE];
    assign extPin2IrqEn = enable_r[BIT_EXT2];
    assign extPin1IrqEn = enable_r[BIT_EXT1];

    // Enable register, unused bits forced to zero
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            enable_r <= ENABLE_RST;
        end else if (wrAcc && paddr == OFF_ENABLE) begin
            enable_r <= pwdata[REG_W-1:0] & IMPL_MASK;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            irqEn_r <= '0;
        end else if (wrAcc && paddr == OFF_IRQ_EN) begin
            irqEn_r <= pwdata[REG_W-1:0] & IMPL_MASK;
        end
    end

    // Edge detect on granted and blocked requests
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            grantPrev_r <= '0;
            blockedPrev_r <= '0;
        end else begin
            grantPrev_r <= grant;
            blockedPrev_r <= blockedEv;
        end
    end

    // Sticky status, set wins over clear
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            status_r <= '0;
        end else begin
            status_r <= (status_r & ~clrMask) | evSet;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            lastEv_r <= EV_NONE;
        end else if (|(blockedEv & ~blockedPrev_r)) begin
            lastEv_r <= EV_BLOCKED;
        end else if (|(grant & ~grantPrev_r)) begin
            lastEv_r <= EV_GRANT_RISE;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((status_r & ~clrMask) | evSet) & irqEn_r);
        end
    end

    iep_gate #(
        .WIDTH(REG_W)
    ) u_gate (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .flags(srcFlags & IMPL_MASK),
        .enables(enable_r),
        .requests(ctrlRequest)
    );

    // APB answer: one access cycle, error on unmapped offsets
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else if (setup) begin
            pready <= 1'b1;
            pslverr <= !known(paddr);
            prdata <= '0;
            if (!pwrite) begin
                unique case (paddr)
                    OFF_ENABLE: prdata <= {16'h0000, enable_r};
                    OFF_STATUS: prdata <= {16'h0000, status_r};
                    OFF_IRQ_EN: prdata <= {16'h0000, irqEn_r};
                    OFF_PENDING: prdata <= {14'h0000, lastEv_r, grant};
                    default: prdata <= '0;
                endcase
            end
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    a_unused_zero: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (enable_r & ~IMPL_MASK) == '0)
        else $error("unused enable bit set");
    a_cmp_write: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (wrAcc && paddr == OFF_ENABLE && pwdata[BIT_CMP3])
        |=> enable_r[BIT_CMP3])
        else $error("comparator 3 enable not stored");
    a_pg_write: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (wrAcc && paddr == OFF_ENABLE)
        |=> enable_r[BIT_PG4:BIT_PG1] == $past(pwdata[BIT_PG4:BIT_PG1]))
        else $error("pulse enables not stored");
    a_req_pass: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (enable_r[BIT_CMP1] && srcFlags[BIT_CMP1]) |=> ctrlRequest[BIT_CMP1])
        else $error("comparator 1 request lost");
    a_req_block: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        !enable_r[BIT_PG2] |=> !ctrlRequest[BIT_PG2])
        else $error("pulse 2 request leaked");
    a_blk_record: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (!enable_r[BIT_EXT1] && srcFlags[BIT_EXT1] && !blockedPrev_r[BIT_EXT1])
        |=> status_r[BIT_EXT1])
        else $error("blocked event not recorded");
    a_unused_read: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (setup && !pwrite && paddr == OFF_ENABLE)
        |=> (prdata[REG_W-1:0] & ~IMPL_MASK) == '0)
        else $error("unused enable bit read as one");
    a_set_wins: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (|evSet) |=> (status_r & $past(evSet)) == $past(evSet))
        else $error("source event lost from status");
    a_clear_done: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (|clrMask) |=> (status_r & $past(clrMask) & ~$past(evSet)) == '0)
        else $error("status bit not cleared");

    // Each named field gates its own source one cycle later
    a_cmp3_gate: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        ctrlRequest[BIT_CMP3] ==
        ($past(srcFlags[BIT_CMP3]) && $past(comparator3IrqEn)))
        else $error("comparator 3 request wrong");
    a_cmp2_gate: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        ctrlRequest[BIT_CMP2] ==
        ($past(srcFlags[BIT_CMP2]) && $past(comparator2IrqEn)))
        else $error("comparator 2 request wrong");
    a_cmp1_gate: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        ctrlRequest[BIT_CMP1] ==
        ($past(srcFlags[BIT_CMP1]) && $past(comparator1IrqEn)))
        else $error("comparator 1 request wrong");
    a_chg_gate: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        ctrlRequest[BIT_CHG] ==
        ($past(srcFlags[BIT_CHG]) && $past(changeNotifyIrqEn)))
        else $error("change notify request wrong");
    a_pg4_gate: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        ctrlRequest[BIT_PG4] ==
        ($past(srcFlags[BIT_PG4]) && $past(pulseGen4IrqEn)))
        else $error("pulse 4 request wrong");
    a_pg3_gate: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        ctrlRequest[BIT_PG3] ==
        ($past(srcFlags[BIT_PG3]) && $past(pulseGen3IrqEn)))
        else $error("pulse 3 request wrong");
    a_pg2_gate: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        ctrlRequest[BIT_PG2] ==
        ($past(srcFlags[BIT_PG2]) && $past(pulseGen2IrqEn)))
        else $error("pulse 2 request wrong");
    a_pg1_gate: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        ctrlRequest[BIT_PG1] ==
        ($past(srcFlags[BIT_PG1]) && $past(pulseGen1IrqEn)))
        else $error("pulse 1 request wrong");
    a_pse_gate: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        ctrlRequest[BIT_PSE] ==
        ($past(srcFlags[BIT_PSE]) && $past(pulseSpecialEventIrqEn)))
        else $error("special event request wrong");
    a_ext2_gate: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        ctrlRequest[BIT_EXT2] ==
        ($past(srcFlags[BIT_EXT2]) && $past(extPin2IrqEn)))
        else $error("pin 2 request wrong");
    a_ext1_gate: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        ctrlRequest[BIT_EXT1] ==
        ($past(srcFlags[BIT_EXT1]) && $past(extPin1IrqEn)))
        else $error("pin 1 request wrong");

    // Each named field takes its bit of an enable write
    a_cmp3_store: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (wrAcc && paddr == OFF_ENABLE)
        |=> comparator3IrqEn == $past(pwdata[BIT_CMP3]))
        else $error("comparator 3 enable not written");
    a_cmp2_store: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (wrAcc && paddr == OFF_ENABLE)
        |=> comparator2IrqEn == $past(pwdata[BIT_CMP2]))
        else $error("comparator 2 enable not written");
    a_cmp1_store: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (wrAcc && paddr == OFF_ENABLE)
        |=> comparator1IrqEn == $past(pwdata[BIT_CMP1]))
        else $error("comparator 1 enable not written");
    a_chg_store: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (wrAcc && paddr == OFF_ENABLE)
        |=> changeNotifyIrqEn == $past(pwdata[BIT_CHG]))
        else $error("change notify enable not written");
    a_pg4_store: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (wrAcc && paddr == OFF_ENABLE)
        |=> pulseGen4IrqEn == $past(pwdata[BIT_PG4]))
        else $error("pulse 4 enable not written");
    a_pg3_store: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (wrAcc && paddr == OFF_ENABLE)
        |=> pulseGen3IrqEn == $past(pwdata[BIT_PG3]))
        else $error("pulse 3 enable not written");
    a_pg2_store: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (wrAcc && paddr == OFF_ENABLE)
        |=> pulseGen2IrqEn == $past(pwdata[BIT_PG2]))
        else $error("pulse 2 enable not written");
    a_pg1_store: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (wrAcc && paddr == OFF_ENABLE)
        |=> pulseGen1IrqEn == $past(pwdata[BIT_PG1]))
        else $error("pulse 1 enable not written");
    a_pse_store: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (wrAcc && paddr == OFF_ENABLE)
        |=> pulseSpecialEventIrqEn == $past(pwdata[BIT_PSE]))
        else $error("special event enable not written");
    a_ext2_store: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (wrAcc && paddr == OFF_ENABLE)
        |=> extPin2IrqEn == $past(pwdata[BIT_EXT2]))
        else $error("pin 2 enable not written");
    a_ext1_store: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (wrAcc && paddr == OFF_ENABLE)
        |=> extPin1IrqEn == $past(pwdata[BIT_EXT1]))
        else $error("pin 1 enable not written");
    a_apb_ready: assert property (@(posedge ref_clk) disable iff (!rst_b)
        setup |=> pready ##1 !pready)
        else $error("apb answer not one cycle");
    a_pin2_read: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (setup && !pwrite && paddr == OFF_ENABLE)
        |=> prdata[BIT_EXT2] == $past(enable_r[BIT_EXT2]))
        else $error("pin 2 enable read wrong");

    c_enable_write: cover property (@(posedge ref_clk)
        wrAcc && paddr == OFF_ENABLE);
    c_req_out: cover property (@(posedge ref_clk) |ctrlRequest);
    c_irq_rise: cover property (@(posedge ref_clk) $rose(irq));
    c_bad_addr: cover property (@(posedge ref_clk) pslverr && pready);
endmodule

/* sim/tb_top.sv */
// Self-checking bench for the interrupt enable bank.
// Assumes iep_pkg offsets and a one-cycle APB answer from iep_bank.
module tb_top
    import iep_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [15:0] srcFlags = 16'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0] ctrlRequest;
    logic irq;
    int errors = 0;
    int totalChecks = 0;
    int seed = 29152;
    logic [31:0] rd;
    logic err;
    logic [15:0] enM;
    logic [15:0] flM;
    logic [15:0] enModel;
    logic [15:0] expQ[$];
    iep_bank iep_bank_i (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .srcFlags(srcFlags),
        .ctrlRequest(ctrlRequest), .irq(irq));
    always #2.5 ref_clk = ~ref_clk;
    task automatic chk(input string nm, input logic [31:0] seen,
        input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (wr && a == OFF_ENABLE) begin
            enModel = d[15:0] & IMPL_MASK;
        end
    endtask
    task automatic giveVerdict();
        $display("checks %0d mismatches %0d", totalChecks, errors);
        if (errors == 0 && totalChecks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        enModel = 16'h0000;
        repeat (20) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        apb(1'b0, OFF_ENABLE, 32'h0);
        chk("enable reset", rd, {16'h0000, enModel});
        apb(1'b1, OFF_ENABLE, 32'hFFFFFFFF);
        apb(1'b0, OFF_ENABLE, 32'h0);
        chk("enable mask", rd, {16'h0000, enModel});
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped err", {31'h0, err}, 32'h1);
        chk("unmapped data", rd, 32'h0);
        $display("test registers done");
        for (int i = 0; i < 20; i++) begin
            enM = 16'($random(seed));
            flM = 16'($random(seed));
            apb(1'b1, OFF_ENABLE, {16'h0000, enM});
            srcFlags <= flM;
            expQ.push_back(flM & enModel);
            repeat (3) @(posedge ref_clk);
            rd = {16'h0000, ctrlRequest};
            chk("request", rd, {16'h0000, expQ.pop_front()});
        end
        $display("test gating done");
        srcFlags <= 16'h0;
        repeat (3) @(posedge ref_clk);
        apb(1'b1, OFF_CLEAR, 32'h0000FFFF);
        apb(1'b1, OFF_ENABLE, 32'h00000001);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk("status cleared", rd, 32'h0);
        srcFlags <= 16'h0009;
        repeat (4) @(posedge ref_clk);
        chk("gated one", {16'h0, ctrlRequest}, 32'h1);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk("status both", rd, 32'h9);
        chk("irq off", {31'h0, irq}, 32'h0);
        apb(1'b0, OFF_PENDING, 32'h0);
        chk("pending", rd, {14'h0000, EV_BLOCKED, 16'h0001});
        apb(1'b1, OFF_IRQ_EN, 32'h00000008);
        repeat (3) @(posedge ref_clk);
        chk("irq on", {31'h0, irq}, 32'h1);
        apb(1'b1, OFF_IRQ_EN, 32'h0);
        repeat (3) @(posedge ref_clk);
        chk("irq masked", {31'h0, irq}, 32'h0);
        srcFlags <= 16'h0;
        apb(1'b1, OFF_IRQ_EN, 32'h0000FFFF);
        apb(1'b1, OFF_CLEAR, 32'h00000009);
        repeat (3) @(posedge ref_clk);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk("status clear", rd, 32'h0);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        $display("test interrupt done");
        apb(1'b1, OFF_ENABLE, 32'h0000FFFF);
        srcFlags <= 16'hFFFF;
        repeat (3) @(posedge ref_clk);
        rd = {16'h0000, ctrlRequest};
        chk("request before reset", rd, {16'h0000, enModel});
        rst_b <= 1'b0;
        enModel = 16'h0000;
        repeat (3) @(posedge ref_clk);
        rd = {16'h0000, ctrlRequest};
        chk("request in reset", rd, 32'h0);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        apb(1'b0, OFF_ENABLE, 32'h0);
        chk("enable after reset", rd, {16'h0000, enModel});
        rd = {16'h0000, ctrlRequest};
        chk("request after reset", rd, 32'h0);
        $display("test reset done");
        giveVerdict();
    end
    initial begin
        repeat (5000) @(posedge ref_clk);
        errors++;
        giveVerdict();
    end
endmodule
